// [asrp_pkg.sv]
// Shared constants and types for the converter standby and read port.
package asrp_pkg;
  localparam int unsigned RESULT_W      = 14;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned FIFO_DEPTH    = 16;
  // Wake-up and quiet times in their own units.
  localparam int unsigned WAKE_SHORT_NS = 2000;
  localparam int unsigned WAKE_LONG_MS  = 15;
  localparam int unsigned WAKE_EXT_NS   = 1000;
  localparam int unsigned QUIET_NS      = 150;
  // Least times round up to whole cycles.
  localparam int unsigned WAKE_SHORT_CYC =
    (WAKE_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_LONG_CYC =
    (WAKE_LONG_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_EXT_CYC =
    (WAKE_EXT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned QUIET_CYC =
    (QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Device-side conversion length and standby span counted as long.
  localparam int unsigned CONV_CYC      = 44;
  localparam int unsigned LONG_STANDBY_N_CYC = 300000;
  localparam int unsigned CNT_W         = 20;
  localparam logic [RESULT_W-1:0] RESULT_RST = 14'h0000;
  localparam logic [RESULT_W-1:0] SAMPLE_INC = 14'h0001;

  typedef enum logic [1:0] {
    ASRP_H_SLEEP, ASRP_H_WAKE, ASRP_H_CONV, ASRP_H_READ
  } asrp_hst_t;
endpackage : asrp_pkg

// [asrp_if.sv]
// Pin bundle between converter end and host controller end.
`timescale 1ns/100ps
`default_nettype none
interface asrp_if;
  import asrp_pkg::*;
  logic                standby_n;
  logic                convert_start;
  logic                cs_n;
  logic                rd_n;
  logic                status;
  logic [RESULT_W-1:0] result_bus_o;
  logic                result_bus_oe;
  logic [RESULT_W-1:0] result_bus;

  // When the converter lets go the bus shows the inverse of the held word.
  // A capture outside the read window therefore cannot pass for good data.
  assign result_bus = result_bus_oe ? result_bus_o : ~result_bus_o;

  modport device (
    input  standby_n, convert_start, cs_n, rd_n,
    output status, result_bus_o, result_bus_oe
  );
  modport host (
    output standby_n, convert_start, cs_n, rd_n,
    input  status, result_bus
  );
endinterface : asrp_if
`default_nettype wire

// [asrp_fifo.sv]
// Parameterised valid/ready FIFO for results on the host side.
`timescale 1ns/100ps
`default_nettype none
module asrp_fifo #(
  parameter int unsigned WIDTH = 14,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wptr_r;
  logic [AW-1:0]    rptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign o_in_ready  = (count_r != (AW+1)'(DEPTH));
  assign o_out_valid = (count_r != '0);
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem_r[rptr_r];

  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem_r[wptr_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      wptr_r  <= '0;
      rptr_r  <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wptr_r <= (wptr_r == AW'(DEPTH-1)) ? '0 : wptr_r + 1'b1;
      end
      if (pop)
      begin
        rptr_r <= (rptr_r == AW'(DEPTH-1)) ? '0 : rptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : asrp_fifo
`default_nettype wire

// [asrp_device.sv]
// Converter end: standby, conversion sequencing and gated result bus.
`timescale 1ns/100ps
`default_nettype none
module asrp_device
  import asrp_pkg::*;
(
  input  wire logic                          i_clk,
  input  wire logic                          i_sys_rst,
  asrp_if.device                             port,
  input  wire logic [asrp_pkg::RESULT_W-1:0] i_sample,
  output logic                               o_powered,
  output logic                               o_converting
);
  import asrp_pkg::*;

  typedef struct packed {
    logic [1:0]          standby_n_s;
    logic [1:0]          conv_s;
    logic [1:0]          cs_s;
    logic [1:0]          rd_s;
    logic                conv_d;
    logic                busy;
    logic [CNT_W-1:0]    cnt;
    logic [RESULT_W-1:0] hold;
    logic [RESULT_W-1:0] result;
    logic                status;
  } asrp_dev_t;

  asrp_dev_t st_r;
  asrp_dev_t st_nxt;

  //////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.standby_n_s = {st_r.standby_n_s[0], port.standby_n};
    st_nxt.conv_s = {st_r.conv_s[0], port.convert_start};
    st_nxt.cs_s   = {st_r.cs_s[0], port.cs_n};
    st_nxt.rd_s   = {st_r.rd_s[0], port.rd_n};
    st_nxt.conv_d = st_r.conv_s[1];
    // Standby only halts the converter core; the result stays readable.
    if (!st_r.standby_n_s[1])
    begin
      st_nxt.busy = 1'b0;
    end
    else if (st_r.conv_s[1] && !st_r.conv_d && !st_r.busy)
    begin
      // Rising edge freezes the sample and starts the count.
      st_nxt.busy = 1'b1;
      st_nxt.hold = i_sample;
      st_nxt.cnt  = CNT_W'(CONV_CYC);
      st_nxt.status = 1'b1;
    end
    else if (st_r.busy)
    begin
      st_nxt.cnt = st_r.cnt - 1'b1;
      if (st_r.cnt == CNT_W'(1))
      begin
        st_nxt.busy   = 1'b0;
        st_nxt.result = st_r.hold;
        // Low marks completion in both forms.
        st_nxt.status = 1'b0;
      end
    end
    else if (!st_r.status && !st_r.conv_s[1])
    begin
      // Start pin low at completion means busy form: stay low until
      // the next start edge; otherwise a one-cycle end pulse.
      st_nxt.status = 1'b0;
    end
    else
    begin
      st_nxt.status = 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st_r <= '{standby_n_s: 2'b00, conv_s: 2'b00, cs_s: 2'b11, rd_s: 2'b11,
                conv_d: 1'b0, busy: 1'b0, cnt: '0,
                hold: RESULT_RST, result: RESULT_RST, status: 1'b1};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Output buffers keep working in standby.
  assign port.result_bus_o  = st_r.result;
  assign port.result_bus_oe = !st_r.cs_s[1] && !st_r.rd_s[1];
  assign port.status        = st_r.status;
  assign o_powered          = st_r.standby_n_s[1];
  assign o_converting       = st_r.busy;
endmodule : asrp_device
`default_nettype wire

// [asrp_host.sv]
// Host controller end: wakes converter, starts, reads on interrupt.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Low standby_n enters standby, high leaves it.
// - Result stays readable while in standby.
// - Internal reference wake: short or long delay.
// - External reference wake waits about one microsecond.
// - Optional standby between conversions limits throughput.
// - Port: result_bus, cs_n, rd_n, status, plus standby_n and convert_start.
// - Falling status interrupts host, one read follows.
// - Select decoded as a single data location.
// - Read strobe gates result, no wait states.
// - Start source may be host or external; here only the host drives convert_start.
// - Bus driven while cs_n, rd_n low, two cycles behind the pins.
// - Start edge holds sample, status tracks conversion.
// - Quiet interval after read before next start.
module asrp_host
  import asrp_pkg::*;
#(
  parameter int unsigned WAKE_LONG = asrp_pkg::WAKE_LONG_CYC,
  parameter int unsigned LONG_STANDBY_N = asrp_pkg::LONG_STANDBY_N_CYC
) (
  input  wire logic                          i_clk,
  input  wire logic                          i_sys_rst,
  asrp_if.host                               port,
  input  wire logic                          i_sample_req,
  input  wire logic                          i_ext_ref,
  input  wire logic                          i_sleep_between,
  output logic                               o_req_ready,
  output logic                               o_res_valid,
  input  wire logic                          i_res_ready,
  output logic      [asrp_pkg::RESULT_W-1:0] o_res_data
);
  import asrp_pkg::*;

  typedef struct packed {
    asrp_hst_t           state;
    logic [1:0]          stat_s;
    logic                stat_d;
    logic [RESULT_W-1:0] bus_s0;
    logic [RESULT_W-1:0] bus_s1;
    logic                standby_n_n;
    logic                conv;
    logic                rd;
    logic [2:0]          rd_cnt;
    logic [CNT_W-1:0]    wait_cnt;
    logic [CNT_W-1:0]    asleep;
    logic                push;
    logic [RESULT_W-1:0] data;
  } asrp_host_st_t;

  asrp_host_st_t st_r;
  asrp_host_st_t st_nxt;
  logic          fifo_ready;

  //////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.stat_s = {st_r.stat_s[0], port.status};
    st_nxt.stat_d = st_r.stat_s[1];
    st_nxt.bus_s0 = port.result_bus;
    st_nxt.bus_s1 = st_r.bus_s0;
    st_nxt.push   = 1'b0;
    if (st_r.wait_cnt != '0)
    begin
      st_nxt.wait_cnt = st_r.wait_cnt - 1'b1;
    end
    if (!st_r.standby_n_n && st_r.asleep != '1)
    begin
      st_nxt.asleep = st_r.asleep + 1'b1;
    end
    unique case (st_r.state)
      ASRP_H_SLEEP:
      begin
        if (i_sample_req && fifo_ready && !st_r.push)
        begin
          st_nxt.standby_n_n = 1'b1;
          st_nxt.state  = ASRP_H_WAKE;
          if (st_r.standby_n_n)
          begin
            st_nxt.wait_cnt = CNT_W'(QUIET_CYC);
          end
          else if (i_ext_ref)
          begin
            st_nxt.wait_cnt = CNT_W'(WAKE_EXT_CYC);
          end
          else if (st_r.asleep >= CNT_W'(LONG_STANDBY_N))
          begin
            st_nxt.wait_cnt = CNT_W'(WAKE_LONG);
          end
          else
          begin
            st_nxt.wait_cnt = CNT_W'(WAKE_SHORT_CYC);
          end
        end
      end
      ASRP_H_WAKE:
      begin
        // No start before the wake or quiet time runs out.
        if (st_r.wait_cnt == '0)
        begin
          st_nxt.conv  = 1'b1;
          st_nxt.state = ASRP_H_CONV;
        end
      end
      ASRP_H_CONV:
      begin
        st_nxt.conv = 1'b0;
        // Completion is taken as an interrupt on the falling status.
        // Busy form leaves status low from the last conversion, so a
        // plain low level would fetch the old word.
        if (!st_r.conv && st_r.stat_d && !st_r.stat_s[1])
        begin
          st_nxt.rd     = 1'b1;
          st_nxt.rd_cnt = 3'd4;
          st_nxt.state  = ASRP_H_READ;
        end
      end
      ASRP_H_READ:
      begin
        // The bus passes the two-stage synchroniser before capture, and
        // the converter's own enable lags the strobe by two cycles, so
        // the strobe stands five cycles.
        st_nxt.rd_cnt = st_r.rd_cnt - 1'b1;
        if (st_r.rd_cnt == 3'd0)
        begin
          st_nxt.rd       = 1'b0;
          st_nxt.data     = st_r.bus_s1;
          st_nxt.push     = 1'b1;
          st_nxt.asleep   = '0;
          st_nxt.standby_n_n   = !i_sleep_between;
          st_nxt.state    = ASRP_H_SLEEP;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st_r <= '{state: ASRP_H_SLEEP, stat_s: 2'b11, stat_d: 1'b1,
                bus_s0: RESULT_RST, bus_s1: RESULT_RST, standby_n_n: 1'b0,
                conv: 1'b0, rd: 1'b0, rd_cnt: 3'd0, wait_cnt: '0,
                asleep: '1, push: 1'b0, data: RESULT_RST};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // One decoded location: select and strobe move together.
  assign port.standby_n     = st_r.standby_n_n;
  assign port.convert_start = st_r.conv;
  assign port.cs_n          = !st_r.rd;
  assign port.rd_n          = !st_r.rd;
  // A word still on its way into the buffer counts as taken space, so a
  // full buffer never silently drops a result.
  assign o_req_ready = (st_r.state == ASRP_H_SLEEP) && fifo_ready
                       && !st_r.push;

  asrp_fifo #(
    .WIDTH (RESULT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (st_r.push),
    .o_in_ready  (fifo_ready),
    .i_in_data   (st_r.data),
    .o_out_valid (o_res_valid),
    .i_out_ready (i_res_ready),
    .o_out_data  (o_res_data)
  );
endmodule : asrp_host
`default_nettype wire

// [asrp_props.sv]
// Pin-level checks between the converter end and the host end.
`timescale 1ns/100ps
`default_nettype none
module asrp_props
  import asrp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic standby_n,
  input wire logic convert_start,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic status,
  input wire logic result_bus_oe
);
  logic [7:0] awake_r;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // Saturates, so a long awake span cannot wrap into a false fresh wake.
  always_ff @(posedge i_clk or posedge i_sys_rst)
    if (i_sys_rst)
      awake_r <= 8'h00;
    else if (!standby_n)
      awake_r <= 8'h00;
    else if (awake_r != 8'hff)
      awake_r <= awake_r + 8'h01;
  ////////////////////////////////////////
  sequence start_s;
    $rose(convert_start);
  endsequence
  sequence conv_s;
    ##[2:5] status [*8] ##[28:40] !status;
  endsequence
  sequence read_s;
    (!rd_n && !cs_n && !status) [*5] ##1 rd_n;
  endsequence
  bus_gate_a:
    assert property ($rose(result_bus_oe) |-> !cs_n && !rd_n)
    else $error("bus driven outside a read");
  bus_release_a:
    assert property ($rose(rd_n) |-> ##[1:3] !result_bus_oe)
    else $error("bus not released");
  start_awake_a:
    assert property (convert_start |-> standby_n)
    else $error("start while in standby");
  wake_delay_a:
    assert property (start_s |-> awake_r >= 8'h13)
    else $error("wake delay too short");
  quiet_time_a:
    assert property ($rose(rd_n) |-> (!convert_start) [*3])
    else $error("quiet time too short");
  start_pulse_a:
    assert property (start_s |=> !convert_start)
    else $error("start not a single pulse");
  conv_status_a:
    assert property (start_s |-> conv_s)
    else $error("status sequence wrong");
  read_strobe_a:
    assert property ($fell(rd_n) |-> read_s)
    else $error("read strobe wrong");
endmodule : asrp_props
`default_nettype wire

// [test_adc_standby_host_read_port.sv]
// Bench joining the converter and host ends across their pin bundle.
`timescale 1ns/100ps
`default_nettype none
module test_adc_standby_host_read_port;
  import asrp_pkg::*;
  localparam int WAKE_L = 50;
  logic                i_clk = 1'b0;
  logic                i_sys_rst = 1'b1;
  logic                i_sample_req = 1'b0;
  logic                i_ext_ref = 1'b0;
  logic                i_sleep_between = 1'b1;
  logic                i_res_ready = 1'b1;
  logic                o_req_ready;
  logic                o_res_valid;
  logic                o_powered;
  logic                o_converting;
  logic [RESULT_W-1:0] i_sample = 14'h0000;
  logic [RESULT_W-1:0] o_res_data;
  int                  num_errors = 0;
  int                  check_count = 0;
  int                  cyc = 0;
  int                  up_at = 0;
  int                  gap = 0;

  asrp_if asrp_if_i ();
  asrp_device asrp_device_i (
    .i_clk, .i_sys_rst, .port (asrp_if_i.device), .i_sample, .o_powered,
    .o_converting
  );
  asrp_host #(.WAKE_LONG (WAKE_L), .LONG_STANDBY_N (100)) asrp_host_i (
    .i_clk, .i_sys_rst, .port (asrp_if_i.host), .i_sample_req, .i_ext_ref,
    .i_sleep_between, .o_req_ready, .o_res_valid, .i_res_ready, .o_res_data
  );
  asrp_props asrp_props_i (
    .i_clk, .i_sys_rst, .standby_n (asrp_if_i.standby_n),
    .convert_start (asrp_if_i.convert_start), .cs_n (asrp_if_i.cs_n),
    .rd_n (asrp_if_i.rd_n), .status (asrp_if_i.status),
    .result_bus_oe (asrp_if_i.result_bus_oe)
  );
  ////////////////////////////////////////
  initial
  begin
    forever #25 i_clk = ~i_clk;
  end

  // Wake gaps are measured on the pins, not taken from the host's counter.
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if ($rose(asrp_if_i.standby_n))
      up_at <= cyc;
    if ($rose(asrp_if_i.convert_start))
      gap <= cyc - up_at;
    if (cyc == 30000)
    begin
      num_errors++;
      $display("wrong value at %0t: run timed out", $time);
      complete_run();
    end
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want)
    begin
      num_errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : chk

  // The sample changes only at the taking edge, so the start captures it.
  task automatic push(input logic [RESULT_W-1:0] v);
    int n;
    n = 0;
    i_sample_req <= 1'b1;
    @(negedge i_clk);
    while (o_req_ready !== 1'b1 && n < 400)
    begin
      @(negedge i_clk);
      n++;
    end
    chk(32'(o_req_ready), 32'h1);
    @(posedge i_clk);
    i_sample <= v;
    i_sample_req <= 1'b0;
  endtask : push

  task automatic pull(input logic [RESULT_W-1:0] v);
    int n;
    n = 0;
    @(negedge i_clk);
    while (o_res_valid !== 1'b1 && n < 2000)
    begin
      @(negedge i_clk);
      n++;
    end
    chk(32'(o_res_valid), 32'h1);
    chk(32'(o_res_data), 32'(v));
    @(posedge i_clk);
  endtask : pull

  task automatic run_one(input logic ext, input logic slp, input int mn,
                         input logic [RESULT_W-1:0] v);
    i_ext_ref <= ext;
    i_sleep_between <= slp;
    push(v);
    pull(v);
    repeat (4) @(negedge i_clk);
    chk(32'(gap >= mn), 32'h1);
    chk(32'(asrp_if_i.standby_n), 32'(!slp));
    chk(32'(o_powered), 32'(!slp));
    chk(32'(o_converting), 32'h0);
    @(posedge i_clk);
  endtask : run_one

  task automatic idle_test;
    @(negedge i_clk);
    chk(32'(asrp_if_i.standby_n), 32'h0);
    chk(32'({asrp_if_i.cs_n, asrp_if_i.rd_n}), 32'h3);
    chk(32'(asrp_if_i.result_bus_oe), 32'h0);
    chk(32'(o_converting), 32'h0);
    chk(32'(asrp_if_i.status), 32'h1);
    @(posedge i_clk);
    $display("idle test done");
  endtask : idle_test

  task automatic wake_test;
    run_one(1'b0, 1'b1, WAKE_L, 14'h1234);
    run_one(1'b1, 1'b1, WAKE_EXT_CYC, 14'h0abc);
    run_one(1'b0, 1'b1, WAKE_SHORT_CYC, 14'h3fff);
    repeat (150) @(posedge i_clk);
    run_one(1'b1, 1'b1, WAKE_EXT_CYC, 14'h2001);
    repeat (150) @(posedge i_clk);
    run_one(1'b0, 1'b1, WAKE_L, 14'h0555);
    $display("wake test done");
  endtask : wake_test

  task automatic awake_test;
    run_one(1'b0, 1'b0, 0, 14'h0001);
    run_one(1'b0, 1'b0, 0, 14'h0002);
    run_one(1'b1, 1'b0, 0, 14'h3ffe);
    $display("awake test done");
  endtask : awake_test

  task automatic fifo_test;
    i_res_ready <= 1'b0;
    for (int k = 0; k < 16; k++)
    begin
      push(14'h0100 + 14'(k));
      @(posedge i_clk);
    end
    i_sample_req <= 1'b1;
    repeat (200) @(negedge i_clk);
    chk(32'(o_req_ready), 32'h0);
    @(posedge i_clk);
    i_sample_req <= 1'b0;
    i_res_ready <= 1'b1;
    for (int k = 0; k < 16; k++)
      pull(14'h0100 + 14'(k));
    repeat (200) @(negedge i_clk);
    chk(32'(o_res_valid), 32'h0);
    $display("buffer test done");
  endtask : fifo_test

  initial
  begin
    repeat (10) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    idle_test();
    wake_test();
    awake_test();
    fifo_test();
    complete_run();
  end
endmodule : test_adc_standby_host_read_port
`default_nettype wire
